// File: rtl/mhp_pkg.sv
/*
 * Constants for the multicast hash, PHY management and pause control
 * register block: register indices, field positions, reset values,
 * state encodings and timing figures.
 * Assumes a 10 MHz system clock and an APB register bus.
 */
package mhp_pkg;
	// Register indices; byte address is four times the index
	localparam int IDX_MAC_MODE = 1;
	localparam int IDX_HASH_HIGH = 4;
	localparam int IDX_HASH_LOW = 5;
	localparam int IDX_MGMT_ACCESS = 6;
	localparam int IDX_MGMT_DATA = 7;
	localparam int IDX_PAUSE_CTRL = 8;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_MAC_MODE = ADDR_W'(IDX_MAC_MODE * 4);
	localparam logic [ADDR_W-1:0] OFF_HASH_HIGH = ADDR_W'(IDX_HASH_HIGH * 4);
	localparam logic [ADDR_W-1:0] OFF_HASH_LOW = ADDR_W'(IDX_HASH_LOW * 4);
	localparam logic [ADDR_W-1:0] OFF_MGMT_ACCESS = ADDR_W'(IDX_MGMT_ACCESS * 4);
	localparam logic [ADDR_W-1:0] OFF_MGMT_DATA = ADDR_W'(IDX_MGMT_DATA * 4);
	localparam logic [ADDR_W-1:0] OFF_PAUSE_CTRL = ADDR_W'(IDX_PAUSE_CTRL * 4);

	// Reset value shared by every register
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	// Mode register fields
	localparam int MODE_TX_ENABLE = 0;
	localparam int MODE_FULL_DUPLEX = 1;
	localparam int MODE_PASS_ALL_MCAST = 2;
	localparam int MODE_W = 3;

	// Management access register fields
	localparam int ACC_BUSY = 0;
	localparam int ACC_WRITE = 1;
	localparam int ACC_INDEX_LSB = 6;
	localparam int ACC_PHYAD_LSB = 11;
	localparam int PHY_FIELD_W = 5;
	localparam int MGMT_DATA_W = 16;

	// Pause control register fields
	localparam int PAUSE_BUSY = 0;
	localparam int PAUSE_RX_ENABLE = 1;
	localparam int PAUSE_PASS_CTRL = 2;
	localparam int PAUSE_TIME_LSB = 16;
	localparam int PAUSE_TIME_W = 16;

	// Hash index layout
	localparam int HASH_INDEX_W = 6;
	localparam int HASH_HALF_SEL = 5;

	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SLOT_TIME_NS = 5120;
	localparam int SLOT_CYCLES_DEF = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BP_TIME_NS = 51200;
	localparam int BP_CYCLES_DEF = (BP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;

	// Management engine states
	typedef enum logic [0:0] {
		MG_IDLE = 1'b0,
		MG_BUSY = 1'b1
	} mhp_mgmt_state_t;

	// Pause generation states
	typedef enum logic [1:0] {
		PS_IDLE = 2'b00,
		PS_SEND = 2'b01,
		PS_BACKPRESS = 2'b10
	} mhp_pause_state_t;
endpackage

// File: rtl/mhp_regs.sv
/*
 * MAC register block: 64-bit multicast hash filter, PHY management
 * access engine and pause (flow control) register with pause frame
 * request, half-duplex backpressure and received pause halting.
 * Assumes one 10 MHz clock, synchronous inputs, an APB3/APB4 master,
 * a MAC transmitter that reports when a pause frame left the wire and
 * an integrated PHY with a request/acknowledge register port.
 */
// Summary of operation
// - 64-bit hash, top index bit picks half
// - index zero low bit0, ones high bit31
// - accept multicast when indexed bit set
// - pass-all-multicast accepts every multicast frame
// - high holds 63:32, low 31:0, reset zero
// - bits 10:6 pick PHY register
// - bit 1 selects write or read
// - busy held during access, cleared at end
// - write data held stable while busy
// - read data valid once busy clears
// - data register low 16 bits, reset zero
// - pause frame carries register pause time
// - full duplex busy until frame sent or transmitter off
// - half duplex busy while backpressure asserted
// - pass-control never blocks frame forwarding
// - enable bit enables received pause handling
// - transmitter off: no pause, no backpressure
// - pause time sits in bits 31:16
// - received pause halts tx time times slot
`timescale 1ns/1ps
module mhp_regs
	import mhp_pkg::*;
#(
	parameter int SLOT_CYCLES = SLOT_CYCLES_DEF,
	parameter int BP_CYCLES = BP_CYCLES_DEF
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// APB slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Multicast hash lookup
	input wire logic rx_mcast_valid,
	input wire logic [HASH_INDEX_W-1:0] rx_hash_index,
	output logic rx_mcast_accept,
	output logic rx_mcast_done,
	// Received pause frames
	input wire logic rx_pause_valid,
	input wire logic [PAUSE_TIME_W-1:0] rx_pause_time,
	output logic rx_ctrl_flag,
	output logic tx_halt,
	// Pause frame generation and backpressure
	output logic pause_tx_req,
	output logic [PAUSE_TIME_W-1:0] pause_tx_time,
	input wire logic pause_tx_done,
	output logic backpressure_on,
	// PHY management port
	output logic phy_req,
	output logic phy_write,
	output logic [PHY_FIELD_W-1:0] phy_addr,
	output logic [PHY_FIELD_W-1:0] phy_index,
	output logic [MGMT_DATA_W-1:0] phy_wdata,
	input wire logic phy_ack,
	input wire logic [MGMT_DATA_W-1:0] phy_rdata
);

	// Byte-lane merge of a write into an old register value
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Address decode: one when the offset is mapped
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		logic hit;
		hit = 1'b0;
		if (a == OFF_MAC_MODE) begin
			hit = 1'b1;
		end else if (a == OFF_HASH_HIGH || a == OFF_HASH_LOW) begin
			hit = 1'b1;
		end else if (a == OFF_MGMT_ACCESS || a == OFF_MGMT_DATA) begin
			hit = 1'b1;
		end else if (a == OFF_PAUSE_CTRL) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	logic rst_meta;
	logic rst_sync_n;
	logic [MODE_W-1:0] mac_mode;
	logic [31:0] multicast_hash_high;
	logic [31:0] multicast_hash_low;
	logic [PHY_FIELD_W-1:0] phy_reg_index;
	logic phy_write_select;
	logic phy_access_busy;
	logic [MGMT_DATA_W-1:0] phy_mgmt_data;
	logic [PAUSE_TIME_W-1:0] pause_time_value;
	logic pass_control_frames;
	logic pause_receive_enable;
	logic pause_busy;
	mhp_mgmt_state_t mgmt_state;
	mhp_pause_state_t pause_state;
	logic [CNT_W-1:0] bp_count;
	logic [CNT_W-1:0] slot_count;
	logic [PAUSE_TIME_W-1:0] quanta_left;
	logic [31:0] next_rdata;
	logic [31:0] wmerged;
	logic wr_go;
	logic tx_enable;
	logic full_duplex;
	logic pass_all_multicast;
	logic hash_bit;

	assign tx_enable = mac_mode[MODE_TX_ENABLE];
	assign full_duplex = mac_mode[MODE_FULL_DUPLEX];
	assign pass_all_multicast = mac_mode[MODE_PASS_ALL_MCAST];

	// Reset release through two flip-flops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Write commits at the edge where pready is seen high
	assign wr_go = psel && penable && pready && pwrite && !pslverr;
	assign wmerged = merge_bytes(prdata, pwdata, pstrb);

	// Read mux for the register being addressed
	always_comb begin
		next_rdata = REG_RESET;
		if (paddr == OFF_MAC_MODE) begin
			next_rdata[MODE_W-1:0] = mac_mode;
		end else if (paddr == OFF_HASH_HIGH) begin
			next_rdata = multicast_hash_high;
		end else if (paddr == OFF_HASH_LOW) begin
			next_rdata = multicast_hash_low;
		end else if (paddr == OFF_MGMT_ACCESS) begin
			next_rdata[ACC_PHYAD_LSB +: PHY_FIELD_W] = phy_addr;
			next_rdata[ACC_INDEX_LSB +: PHY_FIELD_W] = phy_reg_index;
			next_rdata[ACC_WRITE] = phy_write_select;
			next_rdata[ACC_BUSY] = phy_access_busy;
		end else if (paddr == OFF_MGMT_DATA) begin
			next_rdata[MGMT_DATA_W-1:0] = phy_mgmt_data;
		end else if (paddr == OFF_PAUSE_CTRL) begin
			next_rdata[PAUSE_TIME_LSB +: PAUSE_TIME_W] = pause_time_value;
			next_rdata[PAUSE_PASS_CTRL] = pass_control_frames;
			next_rdata[PAUSE_RX_ENABLE] = pause_receive_enable;
			next_rdata[PAUSE_BUSY] = pause_busy;
		end
	end

	// APB answer: pready one cycle into the access phase
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= REG_RESET;
		end else if (clk_en) begin
			if (psel && penable && !pready) begin
				pready <= 1'b1;
				pslverr <= !addr_mapped(paddr);
				prdata <= next_rdata;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	// Mode and hash table registers
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mac_mode <= MODE_W'(REG_RESET);
			multicast_hash_high <= REG_RESET;
			multicast_hash_low <= REG_RESET;
		end else if (clk_en && wr_go) begin
			if (paddr == OFF_MAC_MODE) begin
				mac_mode <= wmerged[MODE_W-1:0];
			end else if (paddr == OFF_HASH_HIGH) begin
				multicast_hash_high <= wmerged;
			end else if (paddr == OFF_HASH_LOW) begin
				multicast_hash_low <= wmerged;
			end
		end
	end

	// Hash bit: top index bit picks the half, low five the bit
	assign hash_bit = rx_hash_index[HASH_HALF_SEL] ?
		multicast_hash_high[rx_hash_index[HASH_HALF_SEL-1:0]] :
		multicast_hash_low[rx_hash_index[HASH_HALF_SEL-1:0]];

	// Multicast accept decision, one cycle after the request
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rx_mcast_accept <= 1'b0;
			rx_mcast_done <= 1'b0;
		end else if (clk_en) begin
			rx_mcast_done <= rx_mcast_valid;
			if (rx_mcast_valid) begin
				rx_mcast_accept <= pass_all_multicast || hash_bit;
			end
		end
	end

	// Management access register and engine
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mgmt_state <= MG_IDLE;
			phy_reg_index <= PHY_FIELD_W'(REG_RESET);
			phy_addr <= PHY_FIELD_W'(REG_RESET);
			phy_write_select <= 1'b0;
			phy_access_busy <= 1'b0;
			phy_req <= 1'b0;
			phy_write <= 1'b0;
			phy_index <= PHY_FIELD_W'(REG_RESET);
		end else if (clk_en) begin
			case (mgmt_state)
				MG_IDLE: begin
					if (wr_go && paddr == OFF_MGMT_ACCESS) begin
						phy_addr <= wmerged[ACC_PHYAD_LSB +: PHY_FIELD_W];
						phy_reg_index <= wmerged[ACC_INDEX_LSB +: PHY_FIELD_W];
						phy_write_select <= wmerged[ACC_WRITE];
						if (wmerged[ACC_BUSY]) begin
							// Launch exactly one access with captured fields
							mgmt_state <= MG_BUSY;
							phy_access_busy <= 1'b1;
							phy_req <= 1'b1;
							phy_index <= wmerged[ACC_INDEX_LSB +: PHY_FIELD_W];
							phy_write <= wmerged[ACC_WRITE];
						end
					end
				end
				MG_BUSY: begin
					// Writes to the access register are ignored while busy
					if (phy_ack) begin
						mgmt_state <= MG_IDLE;
						phy_access_busy <= 1'b0;
						phy_req <= 1'b0;
					end
				end
				default: begin
					mgmt_state <= MG_IDLE;
				end
			endcase
		end
	end

	// Management data: software writes only when idle, PHY reads land at ack
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			phy_mgmt_data <= MGMT_DATA_W'(REG_RESET);
		end else if (clk_en) begin
			if (mgmt_state == MG_BUSY) begin
				if (phy_ack && !phy_write) begin
					phy_mgmt_data <= phy_rdata;
				end
			end else if (wr_go && paddr == OFF_MGMT_DATA) begin
				phy_mgmt_data <= wmerged[MGMT_DATA_W-1:0];
			end
		end
	end

	// Write data seen by the PHY for the whole access
	assign phy_wdata = phy_mgmt_data;

	// Pause control register fields; writes ignored while busy
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pause_time_value <= PAUSE_TIME_W'(REG_RESET);
			pass_control_frames <= 1'b0;
			pause_receive_enable <= 1'b0;
		end else if (clk_en && wr_go && paddr == OFF_PAUSE_CTRL && !pause_busy) begin
			pause_time_value <= wmerged[PAUSE_TIME_LSB +: PAUSE_TIME_W];
			pass_control_frames <= wmerged[PAUSE_PASS_CTRL];
			pause_receive_enable <= wmerged[PAUSE_RX_ENABLE];
		end
	end

	// Time placed into generated pause frames
	assign pause_tx_time = pause_time_value;

	// Pause request: writing busy as one starts a pause or backpressure
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pause_state <= PS_IDLE;
			pause_busy <= 1'b0;
			pause_tx_req <= 1'b0;
			backpressure_on <= 1'b0;
			bp_count <= CNT_W'(REG_RESET);
		end else if (clk_en) begin
			case (pause_state)
				PS_IDLE: begin
					if (wr_go && paddr == OFF_PAUSE_CTRL && wmerged[PAUSE_BUSY]
							&& tx_enable) begin
						pause_busy <= 1'b1;
						if (full_duplex) begin
							pause_state <= PS_SEND;
							pause_tx_req <= 1'b1;
						end else begin
							pause_state <= PS_BACKPRESS;
							backpressure_on <= 1'b1;
							bp_count <= CNT_W'(BP_CYCLES - 1);
						end
					end
				end
				PS_SEND: begin
					// Busy stays up until the frame has left the wire or tx_enable clears
					if (pause_tx_done || !tx_enable) begin
						pause_state <= PS_IDLE;
						pause_busy <= 1'b0;
						pause_tx_req <= 1'b0;
					end
				end
				PS_BACKPRESS: begin
					// Busy tracks backpressure exactly
					if (bp_count == CNT_W'(0) || !tx_enable) begin
						pause_state <= PS_IDLE;
						pause_busy <= 1'b0;
						backpressure_on <= 1'b0;
					end else begin
						bp_count <= bp_count - CNT_W'(1);
					end
				end
				default: begin
					pause_state <= PS_IDLE;
					pause_busy <= 1'b0;
					pause_tx_req <= 1'b0;
					backpressure_on <= 1'b0;
				end
			endcase
		end
	end

	// Packet filter status flag; forwarding itself is never gated
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rx_ctrl_flag <= 1'b0;
		end else if (clk_en) begin
			rx_ctrl_flag <= rx_pause_valid && pass_control_frames;
		end
	end

	// Received pause: halt transmitter for quanta times slot time
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tx_halt <= 1'b0;
			quanta_left <= PAUSE_TIME_W'(REG_RESET);
			slot_count <= CNT_W'(REG_RESET);
		end else if (clk_en) begin
			if (rx_pause_valid && pause_receive_enable && full_duplex) begin
				// A new pause frame restarts the halt time
				tx_halt <= rx_pause_time != PAUSE_TIME_W'(0);
				quanta_left <= rx_pause_time;
				slot_count <= CNT_W'(SLOT_CYCLES - 1);
			end else if (tx_halt) begin
				if (slot_count != CNT_W'(0)) begin
					slot_count <= slot_count - CNT_W'(1);
				end else if (quanta_left == PAUSE_TIME_W'(1)) begin
					tx_halt <= 1'b0;
					quanta_left <= PAUSE_TIME_W'(0);
				end else begin
					quanta_left <= quanta_left - PAUSE_TIME_W'(1);
					slot_count <= CNT_W'(SLOT_CYCLES - 1);
				end
			end
		end
	end

endmodule

// File: verif/mhp_asserts.sv
/* Port checker for the hash, PHY management and pause register block.
   Assumes it is bound to mhp_regs and sees only that module's ports. */
`timescale 1ns/1ps
module mhp_asserts
	import mhp_pkg::*;
#(
	parameter int BP_CYCLES = BP_CYCLES_DEF
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	// APB slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Hash lookup and received pause
	input wire logic rx_mcast_valid,
	input wire logic rx_mcast_done,
	input wire logic rx_pause_valid,
	input wire logic rx_ctrl_flag,
	// Pause generation
	input wire logic pause_tx_req,
	input wire logic [PAUSE_TIME_W-1:0] pause_tx_time,
	input wire logic pause_tx_done,
	input wire logic backpressure_on,
	// PHY management
	input wire logic phy_req,
	input wire logic phy_write,
	input wire logic [PHY_FIELD_W-1:0] phy_index,
	input wire logic [MGMT_DATA_W-1:0] phy_wdata,
	input wire logic phy_ack
);
	logic acc_commit;
	logic pause_commit;
	logic [31:0] last_wdata;
	logic [15:0] bp_cnt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Remember last cycle's commit flags and write data, and the enabled backpressure run length
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			acc_commit <= 1'b0;
			pause_commit <= 1'b0;
			last_wdata <= 32'h0;
			bp_cnt <= 16'h0;
		end else begin
			acc_commit <= psel && penable && pready && pwrite && paddr == OFF_MGMT_ACCESS;
			pause_commit <= psel && penable && pready && pwrite && paddr == OFF_PAUSE_CTRL;
			last_wdata <= pwdata;
			bp_cnt <= backpressure_on ? bp_cnt + {15'h0, clk_en} : 16'h0;
		end
	end
	a_apb_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_slverr_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_hash_answer: assert property (rx_mcast_valid |=> rx_mcast_done)
		else $error("hash lookup not answered next cycle");
	a_ctrl_flag_cause: assert property (rx_ctrl_flag |-> $past(rx_pause_valid))
		else $error("control flag without received pause");
	a_phy_req_hold: assert property (phy_req && !phy_ack |=> phy_req
		&& $stable(phy_wdata) && $stable(phy_index) && $stable(phy_write))
		else $error("management request changed before ack");
	a_phy_req_drop: assert property (phy_req && phy_ack |=> !phy_req)
		else $error("management request held after ack");
	a_phy_launch_fields: assert property ($rose(phy_req) |-> acc_commit
		&& phy_index == last_wdata[ACC_INDEX_LSB +: PHY_FIELD_W]
		&& phy_write == last_wdata[ACC_WRITE])
		else $error("management request not from access write");
	a_pause_time_sent: assert property ($rose(pause_tx_req) |-> pause_commit
		&& pause_tx_time == last_wdata[PAUSE_TIME_LSB +: PAUSE_TIME_W])
		else $error("pause frame time differs from written value");
	a_pause_req_end: assert property (pause_tx_req && pause_tx_done |=> !pause_tx_req)
		else $error("pause request held after frame sent");
	a_bp_length: assert property (bp_cnt <= BP_CYCLES)
		else $error("backpressure longer than its time");
endmodule
bind mhp_regs mhp_asserts #(.BP_CYCLES(BP_CYCLES)) mhp_asserts_i (.clk_sys, .reset_n, .clk_en,
	.paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr, .rx_mcast_valid,
	.rx_mcast_done, .rx_pause_valid, .rx_ctrl_flag, .pause_tx_req, .pause_tx_time,
	.pause_tx_done, .backpressure_on, .phy_req, .phy_write, .phy_index, .phy_wdata, .phy_ack);

// File: verif/mhp_phy_model.sv
/* Behavioural integrated PHY answering the management port.
   Assumes one clock shared with the block; the bench sets the answer delay. */
`timescale 1ns/1ps
module mhp_phy_model
	import mhp_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Answer delay in cycles
	input wire logic [3:0] ack_delay,
	// Management port
	input wire logic phy_req,
	input wire logic phy_write,
	input wire logic [PHY_FIELD_W-1:0] phy_index,
	input wire logic [MGMT_DATA_W-1:0] phy_wdata,
	output logic phy_ack,
	output logic [MGMT_DATA_W-1:0] phy_rdata
);
	logic [MGMT_DATA_W-1:0] regs [32];
	logic [3:0] wait_cnt;
	// One ack per request; read data scrambles outside the ack cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			phy_ack <= 1'b0;
			wait_cnt <= 4'h0;
			phy_rdata <= 16'h0;
			for (int i = 0; i < 32; i++) regs[i] <= 16'h0a00 | 16'(i);
		end else if (phy_req && !phy_ack && wait_cnt == ack_delay) begin
			phy_ack <= 1'b1;
			wait_cnt <= 4'h0;
			phy_rdata <= regs[phy_index];
			if (phy_write) regs[phy_index] <= phy_wdata;
		end else begin
			phy_ack <= 1'b0;
			phy_rdata <= ~phy_rdata;
			if (phy_req && !phy_ack) wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule

// File: verif/testbench.sv
/* Self-checking bench for mhp_regs over APB with a PHY model.
   Assumes a 10 MHz clock, short slot and backpressure counts. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench
	import mhp_pkg::*;
;
	logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic rx_mcast_valid = 0, rx_mcast_accept, rx_mcast_done, rx_pause_valid = 0;
	logic [5:0] rx_hash_index = '0;
	logic [15:0] rx_pause_time = '0, pause_tx_time, phy_wdata, phy_rdata;
	logic rx_ctrl_flag, tx_halt, pause_tx_req, pause_tx_done = 0, backpressure_on;
	logic phy_req, phy_write, phy_ack, clk_en = 1;
	logic [4:0] phy_addr, phy_index;
	logic [3:0] ack_delay = 4'h0;
	int num_errors = 0, checks = 0, n;
	logic [ADDR_W-1:0] regs_a [6] = '{OFF_MAC_MODE, OFF_HASH_HIGH, OFF_HASH_LOW,
		OFF_MGMT_ACCESS, OFF_MGMT_DATA, OFF_PAUSE_CTRL};
	mhp_regs #(.SLOT_CYCLES(2), .BP_CYCLES(4)) mhp_regs_i (.clk_sys, .reset_n,
		.clk_en, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hf), .prdata,
		.pready, .pslverr, .rx_mcast_valid, .rx_hash_index, .rx_mcast_accept, .rx_mcast_done,
		.rx_pause_valid, .rx_pause_time, .rx_ctrl_flag, .tx_halt, .pause_tx_req, .pause_tx_time,
		.pause_tx_done, .backpressure_on, .phy_req, .phy_write, .phy_addr, .phy_index,
		.phy_wdata, .phy_ack, .phy_rdata);
	mhp_phy_model mhp_phy_model_i (.clk_sys, .reset_n, .ack_delay, .phy_req, .phy_write,
		.phy_index, .phy_wdata, .phy_ack, .phy_rdata);
	// Clock
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int k;
		k = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			num_errors++;
			summarize();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] m,
		input logic exp_err);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		`CHK("read data", exp, q & m)
		`CHK("slave error", exp_err, e)
	endtask
	// Poll a busy bit until it reads zero
	task automatic poll(input logic [ADDR_W-1:0] a);
		logic [31:0] q;
		logic e;
		int k;
		k = 0;
		do begin
			apb(1'b0, a, 32'h0, q, e);
			k++;
		end while (q[0] !== 1'b0 && k < 40);
		`CHK("busy cleared", 1'b0, q[0])
		if (q[0] !== 1'b0) summarize();
	endtask
	task automatic look(input logic [5:0] idx, input logic exp);
		@(posedge clk_sys);
		rx_mcast_valid <= 1'b1;
		rx_hash_index <= idx;
		@(posedge clk_sys);
		rx_mcast_valid <= 1'b0;
		@(posedge clk_sys);
		`CHK("mcast accept", exp, rx_mcast_accept)
		`CHK("mcast done", 1'b1, rx_mcast_done)
	endtask
	// Received pause frame: flag, then halt cycles over a window
	task automatic rxp(input logic [15:0] t, input int exp_n, input logic exp_f);
		int k;
		@(posedge clk_sys);
		rx_pause_valid <= 1'b1;
		rx_pause_time <= t;
		@(posedge clk_sys);
		rx_pause_valid <= 1'b0;
		@(posedge clk_sys);
		`CHK("control flag", exp_f, rx_ctrl_flag)
		k = int'(tx_halt === 1'b1);
		repeat (11) begin
			@(posedge clk_sys);
			k += int'(tx_halt === 1'b1);
		end
		`CHK("halt cycles", exp_n, k)
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		foreach (regs_a[i]) rd(regs_a[i], 32'h0, 32'hffff_ffff, 1'b0);
		rd(8'h24, 32'h0, 32'hffff_ffff, 1'b1);
		wr(OFF_HASH_HIGH, 32'h8000_0000);
		wr(OFF_HASH_LOW, 32'h0000_0001);
		rd(OFF_HASH_HIGH, 32'h8000_0000, 32'hffff_ffff, 1'b0);
		look(6'h00, 1'b1);
		look(6'h3f, 1'b1);
		look(6'h1f, 1'b0);
		look(6'h20, 1'b0);
		wr(OFF_MAC_MODE, 32'h4);
		look(6'h1f, 1'b1);
		ack_delay <= 4'hc;
		wr(OFF_MGMT_DATA, 32'h5a3c);
		wr(OFF_MGMT_ACCESS, 32'h08c3);
		rd(OFF_MGMT_ACCESS, 32'h1, 32'h1, 1'b0);
		`CHK("phy address", 5'h01, phy_addr)
		wr(OFF_MGMT_DATA, 32'hffff);
		poll(OFF_MGMT_ACCESS);
		rd(OFF_MGMT_DATA, 32'h5a3c, 32'hffff, 1'b0);
		wr(OFF_MGMT_DATA, 32'h0);
		ack_delay <= 4'h0;
		wr(OFF_MGMT_ACCESS, 32'h08c1);
		poll(OFF_MGMT_ACCESS);
		rd(OFF_MGMT_DATA, 32'h5a3c, 32'hffff, 1'b0);
		wr(OFF_MGMT_ACCESS, 32'h0fc1);
		poll(OFF_MGMT_ACCESS);
		rd(OFF_MGMT_DATA, 32'h0a1f, 32'hffff, 1'b0);
		wr(OFF_MAC_MODE, 32'h3);
		wr(OFF_PAUSE_CTRL, 32'h1234_0001);
		@(posedge clk_sys);
		`CHK("pause request", 1'b1, pause_tx_req)
		`CHK("pause time", 16'h1234, pause_tx_time)
		rd(OFF_PAUSE_CTRL, 32'h1234_0001, 32'hffff_0001, 1'b0);
		pause_tx_done <= 1'b1;
		@(posedge clk_sys);
		pause_tx_done <= 1'b0;
		@(posedge clk_sys);
		`CHK("pause request", 1'b0, pause_tx_req)
		poll(OFF_PAUSE_CTRL);
		wr(OFF_MAC_MODE, 32'h1);
		wr(OFF_PAUSE_CTRL, 32'h1);
		n = 0;
		// Three frozen edges mid-run stretch the backpressure by three cycles
		repeat (20) begin
			@(posedge clk_sys);
			n += int'(backpressure_on === 1'b1);
			clk_en <= (n < 2 || n > 4);
		end
		`CHK("backpressure cycles", 4 + 3, n)
		poll(OFF_PAUSE_CTRL);
		wr(OFF_MAC_MODE, 32'h2);
		wr(OFF_PAUSE_CTRL, 32'h1);
		repeat (2) @(posedge clk_sys);
		`CHK("pause off", 2'b00, {pause_tx_req, backpressure_on})
		wr(OFF_MAC_MODE, 32'h3);
		wr(OFF_PAUSE_CTRL, 32'h6);
		rxp(16'h3, 6, 1'b1);
		wr(OFF_PAUSE_CTRL, 32'h0);
		rxp(16'h3, 0, 1'b0);
		summarize();
	end
endmodule
